/* File: fsac_checker.sv */
/*
  fsac_checker: access checker in front of the program flash array.
  Judges every read, write and erase from the debug port or firmware,
  gates firmware modification with enables and the key sequence, and
  asks for a flash-error device reset on prohibited firmware access.
  Assumes requests, lock_byte_now and flash_busy come from logic on
  pclk, and that presetn is the device reset while por_n is power-on.
*/
// Summary of operation
// - firmware modify needs write enable set first
// - firmware erase needs write and erase enable
// - first n pages locked, n = ~lock byte
// - lock-byte page locked when any bit zero
// - unlocked pages open to every source
// - locked pages: debug refused, unlocked firmware resets
// - lock page read/write follows locked-page treatment
// - lock byte read guarded like locked pages
// - unlocked lock page erasable by debug, firmware
// - locked lock page: only debug device erase
// - changing lock byte bits refused or resets; code permits it while lock_byte_now is all ones
// - reserved area: debug refused, firmware resets
// - debug device erase wipes every page
// - firmware violation resets, sets flash error flag
// - debug violations ignored without reset
// - lock state sampled only after reset
// - written lock byte changes only by device erase
// - interrupts held while flash operation runs
// - erase enable turns write into page erase
// - key codes in order, else modify disabled
`timescale 1ns/1ps
module fsac_checker #(
  parameter logic [fsac_pkg::ADDR_W-1:0] LOCK_BYTE_ADDR = fsac_pkg::LOCK_BYTE_ADDR_DEF,
  parameter logic [fsac_pkg::ADDR_W-1:0] RSV_BASE = fsac_pkg::RSV_BASE_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire fsac_pkg::fsac_req_t req,
  output fsac_pkg::fsac_ans_t ans,
  output logic ans_valid,
  input wire logic [7:0] lock_byte_now,
  input wire logic flash_busy,
  input wire logic irq_pending,
  output logic irq_hold,
  output logic irq_release,
  output logic flash_error_reset
);

  localparam int PW = fsac_pkg::PAGE_W;
  localparam int AW = fsac_pkg::ADDR_W;

  logic [7:0] lock_reg;
  logic lock_valid_reg;
  logic write_en_reg;
  logic erase_en_reg;
  logic flash_err_reg;
  logic irq_held_reg;
  logic busy_d_reg;
  fsac_pkg::fsac_key_t key_reg;
  fsac_pkg::fsac_key_t key_next;
  fsac_pkg::fsac_ans_t ans_next;

  logic [7:0] lock_count; // full lock byte range, may exceed the page count
  logic any_locked;
  logic [PW-1:0] lock_page;
  logic [PW-1:0] acc_page;
  logic [PW-1:0] ins_page;
  logic acc_locked;
  logic ins_locked;
  logic on_lock_page;
  logic on_lock_byte;
  logic in_reserved;
  logic is_modify;
  logic apb_access;
  logic apb_wr;
  logic key_wr;
  logic fw_modify;
  logic violation;
  fsac_pkg::fsac_op_t eff_op;

  // lock byte sampled once after each device reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_reg <= fsac_pkg::LOCK_ALL_ONES;
      lock_valid_reg <= 1'b0;
    end
    else if (!lock_valid_reg)
    begin
      lock_reg <= lock_byte_now;
      lock_valid_reg <= 1'b1;
    end
  end

  // lock decode: count of locked pages from the ones complement
  assign lock_count = ~lock_reg;
  assign any_locked = (lock_reg != fsac_pkg::LOCK_ALL_ONES);
  assign lock_page = LOCK_BYTE_ADDR[AW-1:fsac_pkg::PAGE_LSB];
  assign acc_page = req.addr[AW-1:fsac_pkg::PAGE_LSB];
  assign ins_page = req.iaddr[AW-1:fsac_pkg::PAGE_LSB];

  // page lock state of the target and of the issuing instruction
  assign acc_locked = (8'(acc_page) < lock_count) || (acc_page == lock_page && any_locked);
  assign ins_locked = (8'(ins_page) < lock_count) || (ins_page == lock_page && any_locked);
  assign on_lock_page = (acc_page == lock_page);
  assign on_lock_byte = (req.addr == LOCK_BYTE_ADDR);
  assign in_reserved = (req.addr >= RSV_BASE);

  // firmware write becomes page erase when both enables are set
  always_comb
  begin
    eff_op = req.op;
    if (req.src == fsac_pkg::SRC_FIRMWARE && req.op == fsac_pkg::OP_WRITE && erase_en_reg && write_en_reg)
    begin
      eff_op = fsac_pkg::OP_PAGE_ERASE;
    end
  end

  assign is_modify = (eff_op == fsac_pkg::OP_WRITE) || (eff_op == fsac_pkg::OP_PAGE_ERASE);
  assign fw_modify = req_valid && req.src == fsac_pkg::SRC_FIRMWARE && is_modify;

  // security verdict, before enables and key
  always_comb
  begin
    violation = 1'b0;
    if (req.src == fsac_pkg::SRC_DEBUG && eff_op == fsac_pkg::OP_DEVICE_ERASE)
    begin
      violation = 1'b0;
    end
    else if (eff_op == fsac_pkg::OP_DEVICE_ERASE)
    begin
      violation = 1'b1;
    end
    else if (in_reserved)
    begin
      violation = 1'b1;
    end
    else if (on_lock_byte && is_modify && lock_byte_now != fsac_pkg::LOCK_ALL_ONES)
    begin
      violation = 1'b1;
    end
    else if (on_lock_page && eff_op == fsac_pkg::OP_PAGE_ERASE && any_locked)
    begin
      violation = 1'b1;
    end
    else if (on_lock_page && eff_op == fsac_pkg::OP_PAGE_ERASE)
    begin
      violation = 1'b0;
    end
    else if (acc_locked)
    begin
      // locked page, lock page and lock byte read share one treatment
      violation = (req.src == fsac_pkg::SRC_DEBUG) || !ins_locked;
    end
    else
    begin
      violation = 1'b0;
    end
  end

  // final answer: debug violations ignored, firmware ones reset
  always_comb
  begin
    ans_next = '0;
    ans_next.op = eff_op;
    ans_next.addr = req.addr;
    if (violation && req.src == fsac_pkg::SRC_DEBUG)
    begin
      ans_next.ignore = 1'b1;
    end
    else if (violation)
    begin
      ans_next.error = 1'b1;
    end
    else if (fw_modify && (!write_en_reg || key_reg != fsac_pkg::KEY_OPEN))
    begin
      ans_next.ignore = 1'b1;
    end
    else if (fw_modify && eff_op == fsac_pkg::OP_PAGE_ERASE && !erase_en_reg)
    begin
      ans_next.ignore = 1'b1;
    end
    else
    begin
      ans_next.permit = 1'b1;
    end
  end

  // registered verdict, one cycle after the request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ans <= '0;
      ans_valid <= 1'b0;
    end
    else
    begin
      ans_valid <= req_valid && lock_valid_reg;
      if (req_valid && lock_valid_reg)
      begin
        ans <= ans_next;
      end
      else
      begin
        ans <= '0;
      end
    end
  end

  assign flash_error_reset = ans_valid && ans.error;

  // apb decode
  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pwrite;
  assign key_wr = apb_wr && paddr == fsac_pkg::OFS_KEY_REG;
  assign pready = 1'b1;
  assign pslverr = apb_access && paddr != fsac_pkg::OFS_PROGRAM_STORE_CONTROL_REG && paddr != fsac_pkg::OFS_KEY_REG
                   && paddr != fsac_pkg::OFS_RESET_SOURCE_REGISTER_REG && paddr != fsac_pkg::OFS_LOCK_STAT;

  // program store control bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      write_en_reg <= 1'b0;
      erase_en_reg <= 1'b0;
    end
    else if (apb_wr && paddr == fsac_pkg::OFS_PROGRAM_STORE_CONTROL_REG)
    begin
      write_en_reg <= pwdata[fsac_pkg::BIT_WRITE_EN];
      erase_en_reg <= pwdata[fsac_pkg::BIT_ERASE_EN];
    end
  end

  // key sequencer: in-order codes open one modification
  always_comb
  begin
    key_next = key_reg;
    if (fw_modify && lock_valid_reg && key_reg != fsac_pkg::KEY_OPEN)
    begin
      key_next = fsac_pkg::KEY_DEAD;
    end
    else if (fw_modify && lock_valid_reg && !violation && write_en_reg)
    begin
      key_next = fsac_pkg::KEY_IDLE; // relocks after each firmware modify that passes the security check with write enable set
    end
    else if (key_wr)
    begin
      case (key_reg)
        fsac_pkg::KEY_IDLE:
        begin
          key_next = (pwdata[7:0] == fsac_pkg::KEY_FIRST) ? fsac_pkg::KEY_GOT_FIRST : fsac_pkg::KEY_DEAD;
        end
        fsac_pkg::KEY_GOT_FIRST:
        begin
          key_next = (pwdata[7:0] == fsac_pkg::KEY_SECOND) ? fsac_pkg::KEY_OPEN : fsac_pkg::KEY_DEAD;
        end
        fsac_pkg::KEY_OPEN:
        begin
          key_next = fsac_pkg::KEY_DEAD;
        end
        default:
        begin
          key_next = fsac_pkg::KEY_DEAD;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_reg <= fsac_pkg::KEY_IDLE;
    end
    else
    begin
      key_reg <= key_next;
    end
  end

  // flash error flag survives device reset, cleared by power-on or software
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      flash_err_reg <= 1'b0;
    end
    else if (req_valid && lock_valid_reg && ans_next.error && presetn)
    begin
      flash_err_reg <= 1'b1;
    end
    else if (apb_wr && paddr == fsac_pkg::OFS_RESET_SOURCE_REGISTER_REG && !pwdata[fsac_pkg::BIT_FLASH_ERR])
    begin
      flash_err_reg <= 1'b0;
    end
  end

  // interrupts pending during an operation are held until it ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_held_reg <= 1'b0;
      busy_d_reg <= 1'b0;
    end
    else
    begin
      busy_d_reg <= flash_busy;
      if (flash_busy && irq_pending)
      begin
        irq_held_reg <= 1'b1;
      end
      else if (!flash_busy)
      begin
        irq_held_reg <= 1'b0;
      end
    end
  end

  assign irq_hold = flash_busy;
  assign irq_release = busy_d_reg && !flash_busy && irq_held_reg;

  // register read mux
  always_comb
  begin
    prdata = '0;
    if (apb_access && !pwrite)
    begin
      case (paddr)
        fsac_pkg::OFS_PROGRAM_STORE_CONTROL_REG:
        begin
          prdata[fsac_pkg::BIT_WRITE_EN] = write_en_reg;
          prdata[fsac_pkg::BIT_ERASE_EN] = erase_en_reg;
        end
        fsac_pkg::OFS_KEY_REG:
        begin
          prdata[1:0] = key_reg;
        end
        fsac_pkg::OFS_RESET_SOURCE_REGISTER_REG:
        begin
          prdata[fsac_pkg::BIT_FLASH_ERR] = flash_err_reg;
        end
        fsac_pkg::OFS_LOCK_STAT:
        begin
          prdata[7:0] = lock_reg;
          prdata[fsac_pkg::BIT_ANY_LOCKED] = any_locked;
        end
        default:
        begin
          prdata = '0;
        end
      endcase
    end
  end

endmodule : fsac_checker

/* File: fsac_checker_chk.sv */
/*
  fsac_checker_chk: assertions on the checker ports.
  Assumes binding to fsac_checker with its parameters.
*/
`timescale 1ns/1ps
module fsac_checker_chk #(
  parameter logic [13:0] RSV_BASE = 14'h3E00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic req_valid,
  input wire fsac_pkg::fsac_req_t req,
  input wire fsac_pkg::fsac_ans_t ans,
  input wire logic ans_valid,
  input wire logic flash_busy,
  input wire logic irq_hold,
  input wire logic irq_release,
  input wire logic flash_error_reset
);
  logic armed;
  logic fw;
  logic dbg;
  logic rsv;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // requests count once the lock sample edge has passed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed <= 1'b0;
    else
      armed <= 1'b1;
  end
  // request qualifiers
  assign fw = req_valid && armed && req.src == fsac_pkg::SRC_FIRMWARE;
  assign dbg = req_valid && armed && req.src == fsac_pkg::SRC_DEBUG;
  assign rsv = req.addr >= RSV_BASE;
  a_zero_wait:
    assert property (psel && penable |-> pready) else $error("pready low");
  a_answer_next:
    assert property (req_valid && armed |=> ans_valid) else $error("no answer");
  a_answer_quiet:
    assert property (!req_valid |=> !ans_valid) else $error("stray answer");
  a_one_verdict:
    assert property (ans_valid |-> $onehot({ans.permit, ans.ignore, ans.error})) else $error("verdict");
  a_debug_no_reset:
    assert property (dbg |=> !flash_error_reset) else $error("debug reset");
  a_rsv_fw_reset:
    assert property (fw && rsv |=> flash_error_reset && ans.error) else $error("reserved fw");
  a_rsv_dbg_ignored:
    assert property (dbg && rsv && req.op != fsac_pkg::OP_DEVICE_ERASE |=> ans.ignore) else $error("reserved debug");
  a_dev_erase_debug:
    assert property (dbg && req.op == fsac_pkg::OP_DEVICE_ERASE |=> ans.permit) else $error("erase refused");
  a_dev_erase_fw:
    assert property (fw && req.op == fsac_pkg::OP_DEVICE_ERASE |=> flash_error_reset) else $error("fw erase");
  a_irq_held:
    assert property (flash_busy |-> irq_hold) else $error("irq not held");
  a_irq_release_end:
    assert property (irq_release |-> !flash_busy && $past(flash_busy)) else $error("early irq release");
  c_permit: cover property (ans_valid && ans.permit);
  c_ignore: cover property (ans_valid && ans.ignore);
  c_error: cover property (flash_error_reset);
  c_release: cover property (irq_release);
endmodule : fsac_checker_chk

bind fsac_checker fsac_checker_chk #(.RSV_BASE(RSV_BASE)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .req_valid(req_valid), .req(req), .ans(ans), .ans_valid(ans_valid),
  .flash_busy(flash_busy), .irq_hold(irq_hold), .irq_release(irq_release), .flash_error_reset(flash_error_reset)
);

/* File: fsac_checker_tb.sv */
/*
  fsac_checker_tb: directed tests of the access checker.
  Assumes fsac_requester on the request side, pclk 50 MHz.
*/
`timescale 1ns/1ps
module fsac_checker_tb;
  localparam logic [2:0] P = 3'h4, I = 3'h2, E = 3'h1;
  localparam logic D = 1'b0, F = 1'b1;
  localparam logic [1:0] RD = fsac_pkg::OP_READ, WR = fsac_pkg::OP_WRITE;
  localparam logic [1:0] PE = fsac_pkg::OP_PAGE_ERASE, DE = fsac_pkg::OP_DEVICE_ERASE;
  localparam logic [13:0] LB = fsac_pkg::LOCK_BYTE_ADDR_DEF, LP = 14'h3C00, UP = 14'h1000;
  localparam logic [7:0] CT = fsac_pkg::OFS_PROGRAM_STORE_CONTROL_REG, KY = fsac_pkg::OFS_KEY_REG;
  localparam logic [7:0] RS = fsac_pkg::OFS_RESET_SOURCE_REGISTER_REG, LS = fsac_pkg::OFS_LOCK_STAT;
  logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic go = 1'b0, irq_pending = 1'b0;
  logic [7:0] paddr = 8'h00, wdata = 8'hFF, lock_byte_now;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, req_valid, ans_valid, flash_busy, irq_hold, irq_release, flash_error_reset;
  fsac_pkg::fsac_req_t cmd = '0, req;
  fsac_pkg::fsac_ans_t ans;
  int n_fail = 0, tests_run = 0;
  always #10 pclk = ~pclk;
  fsac_checker dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req(req), .ans(ans), .ans_valid(ans_valid),
    .lock_byte_now(lock_byte_now), .flash_busy(flash_busy), .irq_pending(irq_pending),
    .irq_hold(irq_hold), .irq_release(irq_release), .flash_error_reset(flash_error_reset));
  fsac_requester u_far (.pclk(pclk), .presetn(presetn), .go(go), .cmd(cmd), .wdata(wdata),
    .ans_valid(ans_valid), .ans(ans), .req_valid(req_valid), .req(req),
    .lock_byte_now(lock_byte_now), .flash_busy(flash_busy));
  task automatic cmp(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the slave; only the watchdog ends a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp("prdata", r, x);
    cmp("pslverr", {31'h0, e}, {31'h0, xe});
  endtask : rdc
  // one request, then the verdict one cycle later
  task automatic acc(input logic s, input logic [1:0] o, input logic [13:0] a, input logic [13:0] ia,
    input logic [2:0] v, input logic [1:0] eo);
    int k;
    k = 0;
    cmd <= '{fsac_pkg::fsac_src_t'(s), fsac_pkg::fsac_op_t'(o), a, ia};
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (ans_valid !== 1'b1 && k < 8);
    cmp("verdict", {29'h0, ans.permit, ans.ignore, ans.error}, {29'h0, v});
    cmp("fault_reset", {31'h0, flash_error_reset}, {31'h0, v == E});
    if (v == P)
      cmp("op", {30'h0, ans.op}, {30'h0, eo});
  endtask : acc
  // after a permitted modify: busy holds interrupts, release pulses as busy ends
  task automatic irq_chk(input logic xr);
    @(posedge pclk);
    cmp("irq_hold", {31'h0, irq_hold}, 32'h1);
    repeat (3) @(posedge pclk);
    cmp("irq_release", {31'h0, irq_release}, {31'h0, xr});
    cmp("irq_hold_end", {31'h0, irq_hold}, 32'h0);
  endtask : irq_chk
  task automatic rst();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : rst
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // cut a hang short far past the expected run length
  initial
  begin
    #100000;
    n_fail++;
    end_sim();
  end
  // unlocked, then lock byte written, then locked, then device erase
  initial
  begin
    rst();
    por_n <= 1'b1;
    rdc(LS, 32'h0FF, 1'b0);
    rdc(8'h10, 32'h0, 1'b1);
    acc(D, RD, 14'h0000, 14'h0000, P, RD);
    acc(F, WR, 14'h0200, UP, I, WR);
    rdc(KY, 32'h0, 1'b0);
    acc(D, RD, 14'h3E00, 14'h0000, I, RD);
    acc(F, RD, 14'h3E10, UP, E, RD);
    rdc(RS, 32'h40, 1'b0);
    acc(D, PE, LP, 14'h0000, P, PE);
    irq_chk(1'b0);
    $display("test unlocked done");
    rst();
    wr(CT, 32'h3);
    rdc(CT, 32'h3, 1'b0);
    wr(KY, 32'hA5);
    rdc(KY, 32'h2, 1'b0);
    wr(KY, 32'hF1);
    irq_pending <= 1'b1;
    acc(F, WR, 14'h0300, UP, P, PE);
    irq_chk(1'b1);
    irq_pending <= 1'b0;
    rdc(KY, 32'h1, 1'b0);
    wr(CT, 32'h1);
    wr(KY, 32'hA5);
    wr(KY, 32'hF1);
    wdata <= 8'hFD;
    acc(F, WR, LB, UP, P, WR);
    rdc(LS, 32'h0FF, 1'b0);
    rst();
    rdc(LS, 32'h1FD, 1'b0);
    $display("test lock write done");
    acc(D, RD, 14'h0000, 14'h0000, I, RD);
    acc(F, RD, 14'h0010, UP, E, RD);
    acc(F, RD, 14'h0210, 14'h0000, P, RD);
    acc(D, RD, LP, 14'h0000, I, RD);
    acc(F, RD, LB, UP, E, RD);
    acc(F, RD, LB, 14'h0100, P, RD);
    acc(D, WR, LB, 14'h0000, I, WR);
    acc(F, PE, LP, 14'h0100, E, PE);
    acc(D, RD, 14'h0400, 14'h0000, P, RD);
    acc(D, DE, 14'h0000, 14'h0000, P, DE);
    rst();
    rdc(LS, 32'h0FF, 1'b0);
    // a lock byte whose complement equals the page count locks every page
    wr(CT, 32'h1);
    wr(KY, 32'hA5);
    wr(KY, 32'hF1);
    wdata <= 8'hDF;
    acc(F, WR, LB, UP, P, WR);
    rst();
    rdc(LS, 32'h1DF, 1'b0);
    acc(D, RD, 14'h0A00, 14'h0000, I, RD);
    $display("test locked done");
    end_sim();
  end
endmodule : fsac_checker_tb

/* File: fsac_pkg.sv */
/*
  fsac_pkg: constants, register map, enumerations and carrier structs
  for the flash security access checker.
  Assumes a 16 kB program store in 512-byte pages behind an APB slave.
*/
package fsac_pkg;

  // program store geometry
  localparam int ADDR_W = 14;
  localparam int PAGE_LSB = 9;
  localparam int PAGE_W = ADDR_W - PAGE_LSB;
  localparam logic [ADDR_W-1:0] LOCK_BYTE_ADDR_DEF = 14'h3DFF;
  localparam logic [ADDR_W-1:0] RSV_BASE_DEF = 14'h3E00;
  localparam logic [7:0] LOCK_ALL_ONES = 8'hFF;

  // key codes, written in this order
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;

  // register byte offsets
  localparam logic [7:0] OFS_PROGRAM_STORE_CONTROL_REG = 8'h00;
  localparam logic [7:0] OFS_KEY_REG = 8'h04;
  localparam logic [7:0] OFS_RESET_SOURCE_REGISTER_REG = 8'h08;
  localparam logic [7:0] OFS_LOCK_STAT = 8'h0C;

  // field positions
  localparam int BIT_WRITE_EN = 0;
  localparam int BIT_ERASE_EN = 1;
  localparam int BIT_FLASH_ERR = 6;
  localparam int BIT_ANY_LOCKED = 8;

  // access sources
  typedef enum logic [0:0] {
    SRC_DEBUG = 1'b0,
    SRC_FIRMWARE = 1'b1
  } fsac_src_t;

  // access operations
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_PAGE_ERASE = 2'b10,
    OP_DEVICE_ERASE = 2'b11
  } fsac_op_t;

  // key sequencer states; low two bits read back as the key state
  typedef enum logic [1:0] {
    KEY_DEAD = 2'b00,
    KEY_IDLE = 2'b01,
    KEY_GOT_FIRST = 2'b10,
    KEY_OPEN = 2'b11
  } fsac_key_t;

  // one access request toward the flash array
  typedef struct packed {
    fsac_src_t src;
    fsac_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] iaddr;
  } fsac_req_t;

  // verdict for one access
  typedef struct packed {
    logic permit;
    logic ignore;
    logic error;
    fsac_op_t op;
    logic [ADDR_W-1:0] addr;
  } fsac_ans_t;

endpackage : fsac_pkg

/* File: fsac_requester.sv */
/*
  fsac_requester: behavioural core, debug port and flash array.
  Assumes go and cmd change just after a rising pclk edge.
*/
`timescale 1ns/1ps
module fsac_requester (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire fsac_pkg::fsac_req_t cmd,
  input wire logic [7:0] wdata,
  input wire logic ans_valid,
  input wire fsac_pkg::fsac_ans_t ans,
  output logic req_valid,
  output fsac_pkg::fsac_req_t req,
  output logic [7:0] lock_byte_now,
  output logic flash_busy
);
  logic [7:0] lock_reg = 8'hFF;
  logic [1:0] busy_reg;
  logic ok;
  // each go cycle is one request
  assign req_valid = go;
  assign req = cmd;
  assign lock_byte_now = lock_reg;
  assign flash_busy = busy_reg != 2'h0;
  assign ok = ans_valid && ans.permit;
  // lock byte survives reset; writes clear bits, device erase sets all
  always_ff @(posedge pclk)
  begin
    if (ok && ans.op == fsac_pkg::OP_DEVICE_ERASE)
      lock_reg <= 8'hFF;
    else if (ok && ans.op == fsac_pkg::OP_WRITE && ans.addr == fsac_pkg::LOCK_BYTE_ADDR_DEF)
      lock_reg <= lock_reg & wdata;
  end
  // a write or erase keeps the array busy three cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_reg <= 2'h0;
    else if (ok && ans.op != fsac_pkg::OP_READ)
      busy_reg <= 2'h3;
    else if (busy_reg != 2'h0)
      busy_reg <= busy_reg - 2'h1;
  end
endmodule : fsac_requester
